// ==== rtl/slms_defines.vh ====
// Constants for the serial link mode selector: register offsets, fields,
// reset values, bus addresses and clock thresholds.
// Assumes it is included by bare name from the rtl directory.
`ifndef SLMS_DEFINES_VH
`define SLMS_DEFINES_VH
// ============================================================
// Register offsets
`define SLMS_OFS_PORT_SELECT 8'h1E
`define SLMS_OFS_RX_CAPS 8'h20
`define SLMS_OFS_LINK_MODE 8'h5B
// ============================================================
// Reset values
`define SLMS_RST_PORT_SELECT 8'h01
`define SLMS_RST_RX_CAPS 8'h00
`define SLMS_RST_LINK_MODE 8'h20
// ============================================================
// Link mode control fields
`define SLMS_LM_MODE_MSB 2
`define SLMS_LM_MODE_LSB 0
`define SLMS_LM_PLL_RST_BIT 5
`define SLMS_MODE_FORCE_DUAL 3'h3
`define SLMS_MODE_FORCE_SINGLE 3'h4
// Receiver capability bit meaning dual capable.
`define SLMS_CAP_DUAL_BIT 7
// ============================================================
// Device address base, seven bit; the strap level adds twice its value.
`define SLMS_ADDR_BASE 7'h0C
// ============================================================
// Pixel clock thresholds in MHz.
`define SLMS_SINGLE_MAX_MHZ 8'h69
`define SLMS_LEGACY_MAX_MHZ 8'h55
`define SLMS_DUAL_MAX_MHZ 8'hD2
`define SLMS_DUAL_MIN_MHZ 8'h46
`endif

// ==== rtl/slms_link_mode.v ====
// Link mode selector with its two-wire configuration slave.
// Assumes scl and sda inputs are already synchronous to clock, and that
// the measured pixel clock and receiver detection come from other logic.
//
// Functional notes
// - Single link carries whole stream on one link, up to 105 MHz.
// - Older receivers supported in single link only below 85 MHz.
// - Forced single disables secondary transmitter and back channel.
// - Dual link sends alternating pixels on the two links.
// - Dual link with protection uses one shared protection session.
// - Dual link accepts up to 210 MHz, each port at half rate.
// - Auto dual when dual receiver present and clock at or above minimum.
// - Replicate mode uses second protection core per receiver.
// - Replicate sends same video to two independent receivers.
// - Auto detect classifies single, dual capable or two receivers.
// - Mode choice also uses the measured pixel clock.
// - Receiver only on secondary link gets video alone there.
// - Forced mode suspends automatic detection.
// - PLL reset on frequency change while bit 5 set; host clears it.
// - Bus answers one of eight addresses set by the strap.
// - Clock line input only; data line driven low or released.
// - Acknowledge on address match, stay released otherwise.
`include "slms_defines.vh"
`default_nettype none
module slms_link_mode (
    input wire clock,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [2:0] address_strap_pin,
    input wire rx0_present,
    input wire rx1_present,
    input wire rx0_dual_capable,
    input wire [7:0] pclk_mhz,
    input wire freq_changed,
    input wire legacy_rx,
    input wire protect_en,
    output reg link0_en,
    output reg link1_en,
    output reg secondary_bc_en,
    output reg pixel_split,
    output reg replicate,
    output reg second_cipher_en,
    output reg shared_cipher,
    output reg half_rate,
    output reg pll_reset,
    output reg rate_ok
);
// ============================================================
// Reset release.
reg rst_s1;
reg rst_s2;
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        rst_s1 <= 1'b0;
        rst_s2 <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_s2 <= rst_s1;
    end
end
wire rst_ok = rst_s2;

// ============================================================
// Two-wire slave.
localparam S_IDLE = 5'h01;
localparam S_ADDR = 5'h02;
localparam S_ACK = 5'h04;
localparam S_DATA = 5'h08;
localparam S_READ = 5'h10;
reg [4:0] state;
reg scl_d;
reg sda_d;
reg [3:0] bit_cnt;
reg [7:0] shifter;
reg rnw;
reg [1:0] byte_idx;
reg [7:0] reg_ptr;
reg ack_drive;
reg [7:0] port_select;
reg [7:0] rx_caps [0:1];
reg [7:0] link_mode;
reg [6:0] dev_addr;
wire scl_rise = scl_in & ~scl_d;
wire scl_fall = ~scl_in & scl_d;
wire start_c = scl_in & scl_d & sda_d & ~sda_in;
wire stop_c = scl_in & scl_d & ~sda_d & sda_in;
wire [6:0] strap_addr = `SLMS_ADDR_BASE + {3'h0, address_strap_pin, 1'b0};
wire port_sel = port_select[1];
reg [7:0] rd_data;
always @* begin
    case (reg_ptr)
        `SLMS_OFS_PORT_SELECT: rd_data = port_select;
        `SLMS_OFS_RX_CAPS: rd_data = rx_caps[port_sel];
        `SLMS_OFS_LINK_MODE: rd_data = link_mode;
        default: rd_data = 8'h00;
    endcase
end
// open drain
// The pin is only ever pulled low; a one is the pull-up's job.
assign sda_out = 1'b0;
assign sda_oe = ack_drive;

always @(posedge clock or negedge rst_ok) begin
    if (!rst_ok) begin
        state <= S_IDLE;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        bit_cnt <= 4'h0;
        shifter <= 8'h00;
        rnw <= 1'b0;
        byte_idx <= 2'h0;
        reg_ptr <= 8'h00;
        ack_drive <= 1'b0;
        port_select <= `SLMS_RST_PORT_SELECT;
        rx_caps[0] <= `SLMS_RST_RX_CAPS;
        rx_caps[1] <= `SLMS_RST_RX_CAPS;
        link_mode <= `SLMS_RST_LINK_MODE;
        dev_addr <= 7'h00;
    end else begin
        scl_d <= scl_in;
        sda_d <= sda_in;
        // strap address
        // Sampled every cycle; the strap is static after power-up.
        dev_addr <= strap_addr;
        if (stop_c) begin
            state <= S_IDLE;
            ack_drive <= 1'b0;
        end else if (start_c) begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            ack_drive <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    ack_drive <= 1'b0;
                end
                S_ADDR, S_DATA: begin
                    if (scl_rise) begin
                        shifter <= {shifter[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == S_ADDR) begin
                            if (shifter[7:1] == dev_addr) begin
                                rnw <= shifter[0];
                                ack_drive <= 1'b1;
                                state <= S_ACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end else begin
                            ack_drive <= 1'b1;
                            state <= S_ACK;
                            if (byte_idx == 2'h1) begin
                                reg_ptr <= shifter;
                            end else begin
                                reg_ptr <= reg_ptr + 8'h01;
                                case (reg_ptr)
                                    `SLMS_OFS_PORT_SELECT:
                                        port_select <= shifter;
                                    `SLMS_OFS_RX_CAPS:
                                        rx_caps[port_sel] <= shifter;
                                    `SLMS_OFS_LINK_MODE:
                                        link_mode <= shifter;
                                    default: ;
                                endcase
                            end
                        end
                        if (byte_idx != 2'h2) begin
                            byte_idx <= byte_idx + 2'h1;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        ack_drive <= 1'b0;
                        if (rnw) begin
                            shifter <= rd_data;
                            ack_drive <= ~rd_data[7];
                            reg_ptr <= reg_ptr + 8'h01;
                            state <= S_READ;
                        end else begin
                            state <= S_DATA;
                        end
                    end
                end
                S_READ: begin
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            ack_drive <= 1'b0;
                        end else if (bit_cnt == 4'h8) begin
                            // Master acknowledge sampled from the data line just before this fall.
                            bit_cnt <= 4'h0;
                            shifter <= rd_data;
                            ack_drive <= ~rd_data[7] & ~sda_d;
                            reg_ptr <= reg_ptr + 8'h01;
                            if (sda_d) begin
                                state <= S_IDLE;
                            end
                        end else begin
                            shifter <= {shifter[6:0], 1'b0};
                            ack_drive <= ~shifter[6];
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
end

// ============================================================
// Mode selection.
wire [2:0] mode_field = link_mode[`SLMS_LM_MODE_MSB:`SLMS_LM_MODE_LSB];
wire force_dual = (mode_field == `SLMS_MODE_FORCE_DUAL);
wire force_single = (mode_field == `SLMS_MODE_FORCE_SINGLE);
// Port 0 capability can be forced by software for the control channel.
wire dual_cap = rx0_dual_capable | rx_caps[0][`SLMS_CAP_DUAL_BIT];
wire fast_enough = (pclk_mhz >= `SLMS_DUAL_MIN_MHZ);
reg next_l0;
reg next_l1;
reg next_split;
reg next_rep;
always @* begin
    next_l0 = rx0_present;
    next_l1 = 1'b0;
    next_split = 1'b0;
    next_rep = 1'b0;
    if (force_dual) begin
        next_l0 = 1'b1;
        next_l1 = 1'b1;
        next_split = 1'b1;
    end else if (force_single) begin
        next_l0 = 1'b1;
    end else begin
        if (rx0_present && dual_cap && fast_enough) begin
            next_l1 = 1'b1;
            next_split = 1'b1;
        end else if (rx0_present && rx1_present) begin
            next_l1 = 1'b1;
            next_rep = 1'b1;
        end else if (!rx0_present && rx1_present) begin
            next_l1 = 1'b1;
        end
    end
end

always @(posedge clock or negedge rst_ok) begin
    if (!rst_ok) begin
        link0_en <= 1'b0;
        link1_en <= 1'b0;
        secondary_bc_en <= 1'b0;
        pixel_split <= 1'b0;
        replicate <= 1'b0;
        second_cipher_en <= 1'b0;
        shared_cipher <= 1'b0;
        half_rate <= 1'b0;
        pll_reset <= 1'b0;
        rate_ok <= 1'b0;
    end else begin
        link0_en <= next_l0;
        link1_en <= next_l1;
        secondary_bc_en <= next_l1;
        pixel_split <= next_split;
        replicate <= next_rep;
        second_cipher_en <= next_rep & protect_en;
        shared_cipher <= next_split & protect_en;
        half_rate <= next_split;
        pll_reset <= freq_changed & link_mode[`SLMS_LM_PLL_RST_BIT];
        if (next_split) begin
            rate_ok <= (pclk_mhz <= `SLMS_DUAL_MAX_MHZ);
        end else if (legacy_rx) begin
            rate_ok <= (pclk_mhz < `SLMS_LEGACY_MAX_MHZ);
        end else begin
            rate_ok <= (pclk_mhz <= `SLMS_SINGLE_MAX_MHZ);
        end
    end
end
endmodule
`default_nettype wire

// ==== tb/slms_rx_model.sv ====
// Model of the downstream receivers seen by the link mode selector.
// Assumes the bench picks one attachment case through kind.
`default_nettype none
module slms_rx_model (
    input wire logic [2:0] kind,
    output logic rx0_present,
    output logic rx1_present,
    output logic rx0_dual_capable,
    output logic legacy_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Attachment cases
    // none, single, dual capable, two receivers.
    // A receiver may sit on the secondary link alone.
    assign rx0_present = (kind >= 3'h1) && (kind <= 3'h3);
    assign rx1_present = (kind == 3'h3) || (kind == 3'h4);
    assign rx0_dual_capable = (kind == 3'h2);
    // Case 1 stands for an older receiver.
    assign legacy_rx = (kind == 3'h1);
endmodule
`default_nettype wire

// ==== tb/slms_link_mode_properties.sv ====
// Checker on the link mode selector outputs and its bus data pin.
// Assumes it is bound to slms_link_mode and sees only its ports.
`default_nettype none
module slms_link_mode_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic freq_changed,
    input wire logic protect_en,
    input wire logic link0_en,
    input wire logic link1_en,
    input wire logic pixel_split,
    input wire logic replicate,
    input wire logic second_cipher_en,
    input wire logic shared_cipher,
    input wire logic half_rate,
    input wire logic pll_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Assertions
    a_pll_cause: assert property (pll_reset |-> $past(freq_changed))
        else $error("pll reset without a frequency change");
    a_drive_low: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_ack_rise: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data line pulled while clock high");
    a_ack_held: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data line moved while clock high");
    a_dual_pair: assert property (pixel_split |-> link0_en && link1_en)
        else $error("split pixels without both links");
    a_half_rate: assert property (half_rate |-> pixel_split)
        else $error("half rate outside dual link");
    a_one_mode: assert property (!(pixel_split && replicate))
        else $error("dual and replicate at once");
    a_rep_both: assert property (replicate |-> link0_en && link1_en)
        else $error("replicate without both links");
    a_rep_cipher: assert property (
        replicate && $past(protect_en) |-> second_cipher_en)
        else $error("replicate without second cipher");
    a_shared_one: assert property (shared_cipher |-> pixel_split)
        else $error("shared cipher outside dual link");
    c_dual: cover property (pixel_split && half_rate);
    c_rep: cover property (replicate);
    c_pll: cover property (pll_reset);
endmodule
`default_nettype wire

// ==== tb/tb_slms_link_mode.sv ====
// Self-checking bench for the link mode selector and its bus slave.
// Assumes the design, checker and receiver model are compiled first.
`default_nettype none
module tb_slms_link_mode;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst_n, scl, m_sda, fc, a, pe;
    logic [2:0] strap, kind;
    logic [6:0] adr;
    logic [7:0] pclk, q;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    wire sda_oe, sda_out, r0, r1, dc, lg, l0, l1, bc, sp, rep, c2, shc;
    wire hr, pr, rok;
    // Open-drain wire: released level comes from the pull-up.
    wire sda = m_sda & !(sda_oe & !sda_out);
    slms_rx_model slms_rx_model_i (.kind(kind), .rx0_present(r0),
        .rx1_present(r1), .rx0_dual_capable(dc), .legacy_rx(lg));
    slms_link_mode slms_link_mode_i (.clock(clock), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap_pin(strap), .rx0_present(r0), .rx1_present(r1),
        .rx0_dual_capable(dc), .pclk_mhz(pclk), .freq_changed(fc),
        .legacy_rx(lg), .protect_en(pe), .link0_en(l0), .link1_en(l1),
        .secondary_bc_en(bc), .pixel_split(sp), .replicate(rep),
        .second_cipher_en(c2), .shared_cipher(shc), .half_rate(hr),
        .pll_reset(pr), .rate_ok(rok));
    // ============================================================
    // Bus and check tasks
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bio(input logic b, output logic r);
        tk(1);
        m_sda <= b;
        tk(2);
        scl <= 1'b1;
        tk(2);
        r = sda;
        tk(1);
        scl <= 1'b0;
    endtask
    task automatic st();
        tk(1);
        m_sda <= 1'b1;
        scl <= 1'b1;
        tk(2);
        m_sda <= 1'b0;
        tk(2);
        scl <= 1'b0;
    endtask
    task automatic sp_();
        tk(1);
        m_sda <= 1'b0;
        tk(2);
        scl <= 1'b1;
        tk(2);
        m_sda <= 1'b1;
        tk(2);
    endtask
    task automatic xb(input logic [7:0] d, input logic mb, output logic k);
        for (int i = 7; i >= 0; i--) bio(d[i], q[i]);
        bio(mb, k);
    endtask
    task automatic wb(input logic [7:0] d);
        xb(d, 1'b1, a);
        chk({7'h00, a}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] r, v);
        st();
        wb({adr, 1'b0});
        wb(r);
        wb(v);
        sp_();
    endtask
    task automatic rdc(input logic [7:0] r, e);
        st();
        wb({adr, 1'b0});
        wb(r);
        st();
        wb({adr, 1'b1});
        xb(8'hFF, 1'b1, a);
        sp_();
        chk(q, e);
    endtask
    task automatic mode(input logic [2:0] k, input logic [7:0] f, e);
        kind <= k;
        pclk <= f;
        tk(4);
        chk({5'h00, l0, sp, rep}, e);
    endtask
    task automatic pll(input logic e);
        fc <= 1'b1;
        tk(1);
        fc <= 1'b0;
        // Sampled mid-cycle, away from the edge that moves it.
        @(negedge clock);
        chk({7'h00, pr}, {7'h00, e});
        tk(1);
    endtask
    // ============================================================
    // Scenarios
    task automatic t_regs();
        pll(1'b1);
        rdc(8'h1E, 8'h01);
        rdc(8'h20, 8'h00);
        rdc(8'h5B, 8'h20);
        rdc(8'h00, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_addr();
        for (int i = 0; i < 8; i++) begin
            strap <= i[2:0];
            adr = 7'h0C + 7'(2 * i);
            tk(2);
            st();
            wb({adr, 1'b0});
            sp_();
        end
        st();
        xb(8'h1A, 1'b1, a);
        sp_();
        chk({7'h00, a}, 8'h01);
        $display("test address done");
    endtask
    task automatic t_high_speed_control_channel();
        // Port 1 capability override, then port 0 restored.
        wr(8'h1E, 8'h02);
        wr(8'h20, 8'h8F);
        rdc(8'h20, 8'h8F);
        wr(8'h1E, 8'h01);
        rdc(8'h20, 8'h00);
        rdc(8'h1E, 8'h01);
        $display("test capability done");
    endtask
    task automatic t_auto();
        wr(8'h5B, 8'h00);
        mode(3'h2, 8'd150, 8'h06);
        chk({7'h00, shc}, 8'h01);
        chk({7'h00, rok}, 8'h01);
        mode(3'h2, 8'd70, 8'h06);
        mode(3'h2, 8'd69, 8'h04);
        mode(3'h1, 8'd84, 8'h04);
        chk({7'h00, rok}, 8'h01);
        mode(3'h1, 8'h55, 8'h04);
        chk({7'h00, rok}, 8'h00);
        mode(3'h3, 8'd100, 8'h05);
        chk({7'h00, c2}, 8'h01);
        pe <= 1'b0;
        mode(3'h3, 8'd100, 8'h05);
        chk({6'h00, c2, shc}, 8'h00);
        pe <= 1'b1;
        mode(3'h4, 8'd50, 8'h00);
        chk({7'h00, l1}, 8'h01);
        $display("test auto done");
    endtask
    task automatic t_force();
        // Modes are forced to avoid toggling near the threshold.
        wr(8'h5B, 8'h04);
        mode(3'h2, 8'd150, 8'h04);
        chk({6'h00, l1, bc}, 8'h00);
        wr(8'h5B, 8'h03);
        mode(3'h1, 8'd60, 8'h06);
        chk({7'h00, hr}, 8'h01);
        // The feature bit is cleared once configuration is done.
        rdc(8'h5B, 8'h03);
        pll(1'b0);
        $display("test forced done");
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ============================================================
    // Clock, timeout and main sequence
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // The ceiling is about eleven times the expected run length.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        scl = 1'b1;
        m_sda = 1'b1;
        fc = 1'b0;
        pe = 1'b1;
        strap = 3'h3;
        kind = 3'h0;
        pclk = 8'd50;
        adr = 7'h12;
        tk(8);
        rst_n <= 1'b1;
        tk(4);
        t_regs();
        t_addr();
        t_high_speed_control_channel();
        t_auto();
        t_force();
        end_sim();
    end
endmodule
bind slms_link_mode slms_link_mode_props slms_link_mode_props_i (
    .clock(clock),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .freq_changed(freq_changed),
    .protect_en(protect_en),
    .link0_en(link0_en),
    .link1_en(link1_en),
    .pixel_split(pixel_split),
    .replicate(replicate),
    .second_cipher_en(second_cipher_en),
    .shared_cipher(shared_cipher),
    .half_rate(half_rate),
    .pll_reset(pll_reset)
);
`default_nettype wire
